/* hw/lsdpwm_cfg.svh */
// Purpose: constants of the shutdown and pwm rate control block
// Assumes: 10 MHz system clock, 256 pwm steps per period
// Notes: step lengths derive from the rates and rounded down; never below one cycle
`ifndef LSDPWM_CFG_SVH
`define LSDPWM_CFG_SVH

`define LSDPWM_ADDR_RATE_SEL 8'h4B
`define LSDPWM_RATE_BIT 0
`define LSDPWM_RATE_RESET 1'b0
`define LSDPWM_CLK_HZ 10000000
`define LSDPWM_RATE_LOW_HZ 3000
`define LSDPWM_RATE_HIGH_HZ 22000
`define LSDPWM_STEPS 256
`define LSDPWM_STEP_CYC(hz) (((`LSDPWM_CLK_HZ / ((hz) * `LSDPWM_STEPS)) < 1) ? 1 : \
    (`LSDPWM_CLK_HZ / ((hz) * `LSDPWM_STEPS)))
`define LSDPWM_LOW_STEP_CYC `LSDPWM_STEP_CYC(`LSDPWM_RATE_LOW_HZ)
`define LSDPWM_HIGH_STEP_CYC `LSDPWM_STEP_CYC(`LSDPWM_RATE_HIGH_HZ)

`endif

/* hw/lsdpwm_pkg.sv */
// Purpose: types of the shutdown and pwm rate control block
// Assumes: constants live in lsdpwm_cfg.svh
// Notes: mode codes are one-hot
package lsdpwm_pkg;

    typedef enum logic [1:0] {
        LSDPWM_SHUT = 2'b01,
        LSDPWM_RUN = 2'b10
    } lsdpwm_mode_t;

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        lsdpwm_mode_t mode;
        logic hw_shutdown;
        logic serial_reset;
        logic rate_sel;
        logic rate_high;
        logic [7:0] prescale;
        logic [7:0] step;
        logic period_start;
        logic [7:0] rdata;
        logic rd_hit;
    } lsdpwm_state_t;

endpackage : lsdpwm_pkg

/* hw/lsdpwm_ctrl.sv */
// Purpose: hardware shutdown pin handling and common pwm rate selection
// Assumes: register port driven by the serial interface on sys_clk
// Notes: rate change and restart both land on a period boundary
`include "lsdpwm_cfg.svh"

module lsdpwm_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // shutdown pin, asynchronous
    input wire logic hw_shutdown_n_pin,
    // register port from the serial interface
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_hit,
    // status and control to the rest of the device
    output logic hw_shutdown,
    output logic serial_reset,
    output logic pwm_rate_select_bit,
    output logic pwm_rate_high,
    // common pwm timebase for every led_output_channel
    output logic [7:0] pwm_step,
    output logic pwm_period_start
);
    import lsdpwm_pkg::*;

    localparam int LOW_PERIOD = `LSDPWM_LOW_STEP_CYC * `LSDPWM_STEPS;
    localparam int HIGH_PERIOD = `LSDPWM_HIGH_STEP_CYC * `LSDPWM_STEPS;

    lsdpwm_state_t r_reg;
    lsdpwm_state_t r_next;
    logic rate_wr;
    logic [7:0] step_last;

    assign rate_wr = reg_wr_en && (reg_addr == `LSDPWM_ADDR_RATE_SEL);
    assign step_last = r_reg.rate_high ? 8'(`LSDPWM_HIGH_STEP_CYC - 1) : 8'(`LSDPWM_LOW_STEP_CYC - 1);

    always_comb begin
        r_next = r_reg;
        r_next.pin_meta = hw_shutdown_n_pin;
        r_next.pin_sync = r_reg.pin_meta;
        r_next.pin_prev = r_reg.pin_sync;
        r_next.hw_shutdown = ~r_reg.pin_sync;
        r_next.serial_reset = r_reg.pin_sync & ~r_reg.pin_prev;
        r_next.period_start = 1'b0;
        // writes are taken in every mode; the pin touches no register
        if (rate_wr) begin
            r_next.rate_sel = reg_wdata[`LSDPWM_RATE_BIT];
        end
        r_next.rd_hit = reg_rd_en;
        if (reg_rd_en) begin
            r_next.rdata = (reg_addr == `LSDPWM_ADDR_RATE_SEL) ? {7'h00, r_reg.rate_sel} : 8'h00;
        end
        case (r_reg.mode)
            LSDPWM_SHUT: begin
                // park the timebase so the first run edge opens a full period
                r_next.prescale = step_last;
                r_next.step = 8'hFF;
                if (r_reg.pin_sync) begin
                    r_next.mode = LSDPWM_RUN;
                end else begin
                    // frozen on the way out, so the rate changes no earlier than the first wrap
                    r_next.rate_high = r_reg.rate_sel;
                end
            end
            LSDPWM_RUN: begin
                if (!r_reg.pin_sync) begin
                    r_next.mode = LSDPWM_SHUT;
                end else if (r_reg.prescale >= step_last) begin
                    r_next.prescale = 8'h00;
                    r_next.step = r_reg.step + 8'h01;
                    if (r_reg.step == 8'hFF) begin
                        // a new rate only at the wrap, so no pulse is cut short
                        r_next.period_start = 1'b1;
                        r_next.rate_high = r_reg.rate_sel;
                    end
                end else begin
                    r_next.prescale = r_reg.prescale + 8'h01;
                end
            end
            default: begin
                r_next.mode = LSDPWM_SHUT;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            r_reg <= '{pin_meta: 1'b0, pin_sync: 1'b0, pin_prev: 1'b0, mode: LSDPWM_SHUT,
                       hw_shutdown: 1'b1, serial_reset: 1'b0, rate_sel: `LSDPWM_RATE_RESET,
                       rate_high: `LSDPWM_RATE_RESET, prescale: 8'h00, step: 8'h00,
                       period_start: 1'b0, rdata: 8'h00, rd_hit: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign reg_rd_hit = r_reg.rd_hit;
    assign hw_shutdown = r_reg.hw_shutdown;
    assign serial_reset = r_reg.serial_reset;
    assign pwm_rate_select_bit = r_reg.rate_sel;
    assign pwm_rate_high = r_reg.rate_high;
    assign pwm_step = r_reg.step;
    assign pwm_period_start = r_reg.period_start;

    // helper: cycles since the last period start
    logic [15:0] gap_reg;
    logic seen_reg;
    logic wdata_bit;
    assign wdata_bit = reg_wdata[`LSDPWM_RATE_BIT];
    always_ff @(posedge sys_clk) begin
        if (!nrst || hw_shutdown) begin
            gap_reg <= 16'h0001;
            seen_reg <= 1'b0;
        end else if (pwm_period_start) begin
            gap_reg <= 16'h0001;
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // pin path: two sync flops plus the output flop
    shutdown_enter_a: assert property (!hw_shutdown_n_pin [*4] |-> hw_shutdown)
        else $error("shutdown not entered after pin held low");

    shutdown_leave_a: assert property (hw_shutdown_n_pin [*4] |-> !hw_shutdown)
        else $error("shutdown not left after pin held high");

    serial_reset_edge_a: assert property ($rose(hw_shutdown_n_pin) |-> ##3 serial_reset)
        else $error("no serial reset after pin rising edge");

    serial_reset_pulse_a: assert property (serial_reset |=> !serial_reset)
        else $error("serial reset longer than one cycle");

    serial_reset_wake_a: assert property (serial_reset |-> !hw_shutdown)
        else $error("serial reset while still shut down");

    shutdown_quiet_a: assert property (hw_shutdown |-> !pwm_period_start)
        else $error("period start during shutdown");

    shutdown_park_a: assert property (hw_shutdown && $past(hw_shutdown) && $past(nrst) |->
            pwm_step == 8'hFF)
        else $error("timebase not parked in shutdown");

    // register port
    rate_reg_hold_a: assert property (!rate_wr |=> $stable(pwm_rate_select_bit))
        else $error("rate select changed without a write");

    shutdown_write_a: assert property (rate_wr && hw_shutdown |=> pwm_rate_select_bit == $past(wdata_bit))
        else $error("write lost during shutdown");

    run_write_a: assert property (rate_wr && !hw_shutdown |=> pwm_rate_select_bit == $past(wdata_bit))
        else $error("rate write lost while running");

    read_hit_a: assert property (reg_rd_en |=> reg_rd_hit)
        else $error("read not answered");

    read_idle_a: assert property (!reg_rd_en |=> !reg_rd_hit)
        else $error("read answer without a read");

    read_rate_a: assert property (reg_rd_en && reg_addr == `LSDPWM_ADDR_RATE_SEL |=>
            reg_rdata == {7'h00, $past(pwm_rate_select_bit)})
        else $error("rate select read back wrong");

    read_other_a: assert property (reg_rd_en && reg_addr != `LSDPWM_ADDR_RATE_SEL |=> reg_rdata == 8'h00)
        else $error("unknown address read not zero");

    reset_default_a: assert property ($rose(nrst) |-> !pwm_rate_high && !pwm_rate_select_bit)
        else $error("rate not low after reset");

    // rate in use and timebase
    shut_follow_a: assert property (hw_shutdown && $past(hw_shutdown) |->
            pwm_rate_high == $past(pwm_rate_select_bit))
        else $error("rate in use does not follow register in shutdown");

    rate_boundary_a: assert property ($changed(pwm_rate_high) |-> pwm_period_start || hw_shutdown)
        else $error("rate changed inside a period");

    period_step_a: assert property (pwm_period_start |-> pwm_step == 8'h00)
        else $error("period start away from step zero");

    wrap_start_a: assert property ($past(pwm_step) == 8'hFF && pwm_step == 8'h00 |-> pwm_period_start)
        else $error("step wrap without period start");

    period_length_a: assert property (pwm_period_start && seen_reg && !hw_shutdown |->
            gap_reg == ($past(pwm_rate_high) ? 16'(HIGH_PERIOD) : 16'(LOW_PERIOD)))
        else $error("pwm period length wrong for selected rate");

    high_rate_period_c: cover property (pwm_period_start && pwm_rate_high && seen_reg);
    write_in_shutdown_c: cover property (rate_wr && hw_shutdown);
    wake_edge_c: cover property (serial_reset ##[1:20] pwm_period_start);
    low_rate_period_c: cover property (pwm_period_start && !pwm_rate_high && seen_reg);
    rate_switch_c: cover property (pwm_period_start && $changed(pwm_rate_high));

endmodule : lsdpwm_ctrl

/* sim/lsdpwm_host_model.sv */
// Purpose: host side model driving the shutdown pin and register port
// Assumes: all changes at the falling edge, one-cycle strobes
// Notes: released address and data show the inverse, never the old value
module lsdpwm_host_model (
    // clock
    input wire logic sys_clk,
    // pin and register port
    output logic hw_shutdown_n_pin,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = wr;
        reg_rd_en = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
    task automatic pin(input logic v);
        @(negedge sys_clk);
        hw_shutdown_n_pin = v;
    endtask : pin
    initial begin
        hw_shutdown_n_pin = 1'b1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
endmodule : lsdpwm_host_model

/* sim/tb.sv */
// Purpose: self-checking bench of the shutdown and rate control block
// Assumes: inputs change at the falling edge, outputs read there too
// Notes: reads queue their expected data, a monitor compares on each hit
`include "lsdpwm_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, nrst, hw_shutdown_n_pin, reg_wr_en, reg_rd_en, reg_rd_hit, hw_shutdown, serial_reset;
    logic pwm_rate_select_bit, pwm_rate_high, pwm_period_start, prev_high;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pwm_step;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h256027F0;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    lsdpwm_ctrl DUT (.sys_clk, .nrst, .hw_shutdown_n_pin, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_hit, .hw_shutdown, .serial_reset, .pwm_rate_select_bit, .pwm_rate_high,
        .pwm_step, .pwm_period_start);
    lsdpwm_host_model host (.sys_clk, .hw_shutdown_n_pin, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expd);
        cmp_count++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", name, expd, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd
    // sync on one period start, then count cycles to the next
    task automatic period(input int n);
        int c;
        c = 0;
        do @(negedge sys_clk); while (pwm_period_start !== 1'b1);
        do begin
            @(negedge sys_clk);
            c++;
        end while (pwm_period_start !== 1'b1);
        check("period", 16'(c), 16'(n));
        check("step", pwm_step, 16'h0000);
    endtask : period
    always @(negedge sys_clk) begin
        if (reg_rd_hit === 1'b1) check("rdata", reg_rdata, exp_q.pop_front());
        if (nrst && hw_shutdown === 1'b0 && pwm_rate_high !== prev_high)
            check("rate_edge", pwm_period_start, 16'h0001);
        prev_high <= pwm_rate_high;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        nrst = 1'b0;
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("shut", hw_shutdown, 16'h0000);
        check("rate", {pwm_rate_select_bit, pwm_rate_high}, 16'h0000);
        rd(8'h4B, 8'h00);
        period(`LSDPWM_STEPS * `LSDPWM_LOW_STEP_CYC);
        $display("test defaults done");
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        host.access(1'b1, 8'h4B, seed[7:0] | 8'h01);
        rd(8'h4B, 8'h01);
        host.access(1'b1, 8'h4A, 8'hFF);
        rd(8'h4A, 8'h00);
        period(`LSDPWM_STEPS * `LSDPWM_HIGH_STEP_CYC);
        $display("test high rate done");
        host.pin(1'b0);
        repeat (4) @(negedge sys_clk);
        check("shut", hw_shutdown, 16'h0001);
        host.access(1'b1, 8'h4B, seed[15:8] & 8'hFE);
        rd(8'h4B, 8'h00);
        host.access(1'b1, 8'h4B, 8'h01);
        host.pin(1'b1);
        repeat (3) @(negedge sys_clk);
        check("sreset", {serial_reset, hw_shutdown}, 16'h0002);
        check("kept", pwm_rate_select_bit, 16'h0001);
        period(`LSDPWM_STEPS * `LSDPWM_HIGH_STEP_CYC);
        $display("test shutdown done");
        check("queue", 16'(exp_q.size()), 16'h0000);
        stop_test();
    end
endmodule : tb
